/* File: hw/phvc_capregs.sv */
/*
   Configuration-space capability registers of a primary or secondary PCI port:
   interrupt line field, hot swap control and status, product
   information capability and data register with EEPROM transfers.
   Assumes one configuration access port of this PCI port, an EEPROM
   byte controller outside, and misc control bits supplied as inputs.
*/
`default_nettype none

// Functional notes
// - eight-bit read/write interrupt line field, reset to zero
// - hot swap register exists only on the primary port
// - two-port parts enable one port as primary; single-port is primary
// - entry flag set by insertion event, reset 0, write 1 clears
// - removal flag set by extraction event, reset 0, write 1 clears
// - programming interface code reads 00, read only
// - led bit read/write, reset 0, one lights the led
// - mask bit read/write, reset 0, one masks the event signal
// - hot swap code 06; link E8 when enabled and EEPROM found
// - product information code 03, link 00 ends the list
// - product information only on primary; else reads zero, writes dropped
// - product information disabled whenever the hot swap link is zero
// - software clears complete flag; device reads EEPROM then sets flag
// - software sets flag after data; device writes EEPROM then clears
// - eight-bit EEPROM byte offset, reset 00, read/write
// - shared device: 192 bytes, first 64 read only; separate: 192 writable
// - data register reset 0, usable only when enabled, else reads 0
module phvc_capregs
   import phvc_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        RSTN,
   input  wire logic        PRIMARY_PORT_RESET,
   input  wire logic        DUAL_PORT_CONFIG,
   input  wire logic        PORT_PRIMARY_SELECT,
   input  wire logic        PRODUCT_INFO_ENABLE,
   input  wire logic        EEPROM_DETECTED,
   input  wire logic        SHARED_EEPROM,
   input  wire logic        BOARD_INSERTED,
   input  wire logic        BOARD_REMOVED,
   input  wire logic        CFG_REQ,
   input  wire logic        CFG_WE,
   input  wire logic [7:0]  CFG_ADDR,
   input  wire logic [3:0]  CFG_BE,
   input  wire logic [31:0] CFG_WDATA,
   output logic [31:0]      CFG_RDATA,
   output logic             CFG_ACK,
   output logic             HOTSWAP_EVENT_N,
   output logic             STATUS_LED,
   output logic             EE_REQ,
   output logic             EE_WRITE,
   output logic [7:0]       EE_ADDR,
   output logic [7:0]       EE_WDATA,
   input  wire logic [7:0]  EE_RDATA,
   input  wire logic        EE_DONE
);

   typedef struct packed
   {
      logic [7:0]  int_line;
      logic        board_entry_flag;
      logic        board_removal_flag;
      logic        status_led_on;
      logic        hotswap_signal_mask;
      logic [7:0]  product_info_addr;
      logic        eeprom_op_complete;
      logic [31:0] product_info_word;
      logic [31:0] rdata;
      logic        ack;
      logic        event_n;
      logic        led;
   } phvc_regs_t;

   phvc_regs_t r;
   phvc_regs_t next_r;

   ////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [7:0] merge_byte(input logic [7:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] be,
                                             input int lane);
      merge_byte = be[lane] ? wd[lane*8 +: 8] : old;
   endfunction : merge_byte

   function automatic logic hit(input logic [7:0] a,
                                input logic [7:0] ofs);
      hit = (a[7:2] == ofs[7:2]);
   endfunction : hit

   ////////////////////////////////////////////////////////////////////////
   // port role, capability chain and transfer sequencer hookup
   logic        rst_n;
   logic        is_primary;
   logic        pd_on;
   logic [7:0]  hs_link;
   logic        wr_acc;
   logic        x_start;
   logic        x_write;
   logic [7:0]  x_base;
   logic        x_busy;
   logic        x_done;
   logic [31:0] x_rdata;

   assign rst_n      = RSTN && !PRIMARY_PORT_RESET;
   assign is_primary = !DUAL_PORT_CONFIG || PORT_PRIMARY_SELECT;
   assign hs_link    = (PRODUCT_INFO_ENABLE && EEPROM_DETECTED)
                       ? LINK_PRODINFO : LINK_END;
   assign pd_on      = is_primary && (hs_link != LINK_END);
   assign wr_acc     = CFG_REQ && CFG_WE;

   phvc_xfer #(
      .WORD_BYTES_P (WORD_BYTES)
   ) u_xfer (
      .clk        (CLK),
      .rst_n      (rst_n),
      .start      (x_start),
      .write      (x_write),
      .shared_rom (SHARED_EEPROM),
      .base       (x_base),
      .wdata      (r.product_info_word),
      .busy       (x_busy),
      .done       (x_done),
      .rdata      (x_rdata),
      .ee_req     (EE_REQ),
      .ee_write   (EE_WRITE),
      .ee_addr    (EE_ADDR),
      .ee_wdata   (EE_WDATA),
      .ee_rdata   (EE_RDATA),
      .ee_done    (EE_DONE)
   );

   ////////////////////////////////////////////////////////////////////////
   // next state
   logic [31:0] rd;

   always_comb
   begin
      next_r  = r;
      rd      = RST_WORD;
      x_start = 1'b0;
      x_write = r.eeprom_op_complete;
      x_base  = r.product_info_addr;
      next_r.ack = CFG_REQ;

      // register writes
      if (wr_acc && hit(CFG_ADDR, OFS_INT_LINE_REG))
      begin
         next_r.int_line = merge_byte(r.int_line, CFG_WDATA, CFG_BE,
                                      LANE_CODE);
      end
      if (wr_acc && is_primary && hit(CFG_ADDR, OFS_HOTSWAP_CSR))
      begin
         if (CFG_BE[LANE_CTRL])
         begin
            if (CFG_WDATA[HS_ENTRY_BIT])
            begin
               next_r.board_entry_flag = 1'b0;
            end
            if (CFG_WDATA[HS_REMOVAL_BIT])
            begin
               next_r.board_removal_flag = 1'b0;
            end
            next_r.status_led_on       = CFG_WDATA[HS_LED_BIT];
            next_r.hotswap_signal_mask = CFG_WDATA[HS_MASK_BIT];
         end
      end
      if (wr_acc && pd_on && !x_busy && hit(CFG_ADDR, OFS_PRODINFO_CAP))
      begin
         next_r.product_info_addr = merge_byte(r.product_info_addr,
                                   CFG_WDATA, CFG_BE, LANE_CTRL);
         if (CFG_BE[LANE_TOP])
         begin
            next_r.eeprom_op_complete = CFG_WDATA[PD_FLAG_BIT];
            x_start = 1'b1;
            x_write = CFG_WDATA[PD_FLAG_BIT];
            x_base  = next_r.product_info_addr;
         end
      end
      if (wr_acc && pd_on && !x_busy && hit(CFG_ADDR, OFS_PRODINFO_DATA))
      begin
         for (int i = 0; i < WORD_BYTES; i++)
         begin
            next_r.product_info_word[i*8 +: 8] =
               merge_byte(r.product_info_word[i*8 +: 8], CFG_WDATA,
                          CFG_BE, i);
         end
      end

      // hardware events win over software clears
      if (BOARD_INSERTED)
      begin
         next_r.board_entry_flag = 1'b1;
      end
      if (BOARD_REMOVED)
      begin
         next_r.board_removal_flag = 1'b1;
      end

      // transfer finished: flag turns over only now
      if (x_done)
      begin
         if (!r.eeprom_op_complete)
         begin
            next_r.product_info_word = x_rdata;
         end
         next_r.eeprom_op_complete = !r.eeprom_op_complete;
      end

      // read mux
      if (hit(CFG_ADDR, OFS_INT_LINE_REG))
      begin
         rd[INT_LINE_LSB +: 8] = r.int_line;
      end
      else if (hit(CFG_ADDR, OFS_HOTSWAP_CSR) && is_primary)
      begin
         rd[CAP_CODE_LSB +: 8]   = CAP_CODE_HOTSWAP;
         rd[CAP_LINK_LSB +: 8]   = hs_link;
         rd[HS_ENTRY_BIT]        = r.board_entry_flag;
         rd[HS_REMOVAL_BIT]      = r.board_removal_flag;
         rd[HS_PROG_LSB +: 2]    = PROG_IFACE_CODE;
         rd[HS_LED_BIT]          = r.status_led_on;
         rd[HS_MASK_BIT]         = r.hotswap_signal_mask;
      end
      else if (hit(CFG_ADDR, OFS_PRODINFO_CAP) && is_primary)
      begin
         rd[CAP_CODE_LSB +: 8]   = CAP_CODE_PRODINFO;
         rd[CAP_LINK_LSB +: 8]   = LINK_END;
         rd[PD_ADDR_LSB +: 8]    = r.product_info_addr;
         rd[PD_FLAG_BIT]         = r.eeprom_op_complete;
      end
      else if (hit(CFG_ADDR, OFS_PRODINFO_DATA) && pd_on)
      begin
         rd = r.product_info_word;
      end
      next_r.rdata = (CFG_REQ && !CFG_WE) ? rd : RST_WORD;

      // pins
      next_r.event_n = !((next_r.board_entry_flag ||
                          next_r.board_removal_flag) &&
                         !next_r.hotswap_signal_mask);
      next_r.led = next_r.status_led_on;
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge CLK)
   begin
      if (!rst_n)
      begin
         r         <= '0;
         r.event_n <= 1'b1;
      end
      else
      begin
         r <= next_r;
      end
   end

   assign CFG_RDATA       = r.rdata;
   assign CFG_ACK         = r.ack;
   assign HOTSWAP_EVENT_N = r.event_n;
   assign STATUS_LED      = r.led;

endmodule : phvc_capregs

`default_nettype wire

/* File: hw/phvc_pkg.sv */
/*
   Package of the hot swap and product information capability block:
   configuration offsets, field positions, capability codes, reset values
   and the transfer sequencer state encoding.
   Assumes configuration offsets are byte addresses of aligned dwords.
*/
`default_nettype none

package phvc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // configuration offsets (byte addresses)
   localparam logic [7:0] OFS_INT_LINE_REG   = 8'h3C;
   localparam logic [7:0] OFS_HOTSWAP_CSR    = 8'hE4;
   localparam logic [7:0] OFS_PRODINFO_CAP   = 8'hE8;
   localparam logic [7:0] OFS_PRODINFO_DATA  = 8'hEC;

   ////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int CAP_CODE_LSB       = 0;
   localparam int CAP_LINK_LSB       = 8;
   localparam int INT_LINE_LSB       = 0;
   localparam int HS_ENTRY_BIT       = 23;
   localparam int HS_REMOVAL_BIT     = 22;
   localparam int HS_PROG_LSB        = 20;
   localparam int HS_LED_BIT         = 19;
   localparam int HS_MASK_BIT        = 17;
   localparam int PD_ADDR_LSB        = 16;
   localparam int PD_FLAG_BIT        = 31;
   localparam int LANE_CODE          = 0;
   localparam int LANE_LINK          = 1;
   localparam int LANE_CTRL          = 2;
   localparam int LANE_TOP           = 3;

   ////////////////////////////////////////////////////////////////////////
   // constant field values and reset values
   localparam logic [7:0]  CAP_CODE_HOTSWAP  = 8'h06;
   localparam logic [7:0]  CAP_CODE_PRODINFO = 8'h03;
   localparam logic [7:0]  LINK_PRODINFO     = 8'hE8;
   localparam logic [7:0]  LINK_END          = 8'h00;
   localparam logic [1:0]  PROG_IFACE_CODE   = 2'b00;
   localparam logic [7:0]  RST_BYTE          = 8'h00;
   localparam logic [31:0] RST_WORD          = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////
   // product information area
   localparam logic [8:0]  PD_RO_LIMIT       = 9'h040;
   localparam logic [8:0]  PD_AREA_LIMIT     = 9'h0C0;
   localparam int          WORD_BYTES        = 4;

   typedef enum logic [1:0]
   {
      PHVC_X_IDLE  = 2'b00,
      PHVC_X_ISSUE = 2'b01,
      PHVC_X_WAIT  = 2'b11,
      PHVC_X_STEP  = 2'b10
   } phvc_xstate_t;

endpackage : phvc_pkg

`default_nettype wire

/* File: hw/phvc_xfer.sv */
/*
   Product information transfer sequencer: moves one data word between
   the block and the serial EEPROM controller one byte at a time.
   Assumes the controller takes a one-cycle ee_req and answers each
   byte with a one-cycle ee_done, any number of cycles later.
*/
`default_nettype none

module phvc_xfer
   import phvc_pkg::*;
#(
   parameter int WORD_BYTES_P = phvc_pkg::WORD_BYTES
)
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        start,
   input  wire logic        write,
   input  wire logic        shared_rom,
   input  wire logic [7:0]  base,
   input  wire logic [31:0] wdata,
   output logic             busy,
   output logic             done,
   output logic [31:0]      rdata,
   output logic             ee_req,
   output logic             ee_write,
   output logic [7:0]       ee_addr,
   output logic [7:0]       ee_wdata,
   input  wire logic [7:0]  ee_rdata,
   input  wire logic        ee_done
);

   typedef struct packed
   {
      phvc_xstate_t st;
      logic [1:0]   idx;
      logic [7:0]   base;
      logic [31:0]  data;
      logic         write;
      logic         shared;
      logic         done;
      logic         req;
      logic [7:0]   addr;
      logic [7:0]   wbyte;
   } phvc_xregs_t;

   phvc_xregs_t r;
   phvc_xregs_t next_r;

   ////////////////////////////////////////////////////////////////////////
   // area check: end of area, and read-only head in the shared device
   function automatic logic byte_ok(input logic [8:0] a,
                                    input logic       wr,
                                    input logic       shr);
      byte_ok = (a < PD_AREA_LIMIT) && (!wr || !shr || a >= PD_RO_LIMIT);
   endfunction : byte_ok

   logic [8:0] cur;

   always_comb
   begin
      cur    = {1'b0, r.base} + {7'b000_0000, r.idx};
      next_r = r;
      next_r.done = 1'b0;
      next_r.req  = 1'b0;
      case (r.st)
         PHVC_X_IDLE:
         begin
            if (start)
            begin
               next_r.write  = write;
               next_r.shared = shared_rom;
               next_r.base   = base;
               next_r.data   = write ? wdata : RST_WORD;
               next_r.idx    = 2'b00;
               next_r.st     = PHVC_X_ISSUE;
            end
         end
         PHVC_X_ISSUE:
         begin
            if (byte_ok(cur, r.write, r.shared))
            begin
               next_r.req   = 1'b1;
               next_r.addr  = cur[7:0];
               next_r.wbyte = r.data[{r.idx, 3'b000} +: 8];
               next_r.st    = PHVC_X_WAIT;
            end
            else
            begin
               next_r.st = PHVC_X_STEP;
            end
         end
         PHVC_X_WAIT:
         begin
            if (ee_done)
            begin
               if (!r.write)
               begin
                  next_r.data[{r.idx, 3'b000} +: 8] = ee_rdata;
               end
               next_r.st = PHVC_X_STEP;
            end
         end
         PHVC_X_STEP:
         begin
            if (32'(r.idx) == WORD_BYTES_P - 1)
            begin
               next_r.done = 1'b1;
               next_r.st   = PHVC_X_IDLE;
            end
            else
            begin
               next_r.idx = r.idx + 2'b01;
               next_r.st  = PHVC_X_ISSUE;
            end
         end
         default:
         begin
            next_r.st = PHVC_X_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         r <= '0;
      end
      else
      begin
         r <= next_r;
      end
   end

   assign busy     = (r.st != PHVC_X_IDLE) || r.done;
   assign done     = r.done;
   assign rdata    = r.data;
   assign ee_req   = r.req;
   assign ee_write = r.write;
   assign ee_addr  = r.addr;
   assign ee_wdata = r.wbyte;

endmodule : phvc_xfer

`default_nettype wire

/* File: sim/phvc_ee_model.sv */
/*
   Byte model of the serial EEPROM controller behind the block.
   Assumes one-cycle requests whose address and data hold until done.
*/
`default_nettype none

module phvc_ee_model
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       slow,
   input  wire logic       ee_req,
   input  wire logic       ee_write,
   input  wire logic [7:0] ee_addr,
   input  wire logic [7:0] ee_wdata,
   output logic      [7:0] ee_rdata,
   output logic            ee_done
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] mem [256];
   logic [3:0] cnt;
   logic       busy;

   ////////////////////////////////////////////////////////////////////////
   // one byte per request, answered promptly or after ten cycles
   always @(posedge clk)
   begin
      ee_done <= 1'b0;
      ee_rdata <= ~ee_rdata;
      if (!rst_n)
      begin
         busy <= 1'b0;
         ee_rdata <= 8'h5a;
      end
      else if (ee_req)
      begin
         busy <= 1'b1;
         cnt <= slow ? 4'h9 : 4'h0;
      end
      else if (busy && cnt != 4'h0)
         cnt <= cnt - 4'h1;
      else if (busy)
      begin
         busy <= 1'b0;
         ee_done <= 1'b1;
         if (ee_write)
            mem[ee_addr] <= ee_wdata;
         else
            ee_rdata <= mem[ee_addr];
      end
   end
endmodule : phvc_ee_model

`default_nettype wire

/* File: sim/phvc_capregs_checker.sv */
/*
   Port checks of the capability register block.
   Assumes the single clock and both synchronous resets of the block.
*/
`default_nettype none

module phvc_capregs_checker
   import phvc_pkg::*;
(
   input wire logic        CLK,
   input wire logic        RSTN,
   input wire logic        PRIMARY_PORT_RESET,
   input wire logic        DUAL_PORT_CONFIG,
   input wire logic        PORT_PRIMARY_SELECT,
   input wire logic        PRODUCT_INFO_ENABLE,
   input wire logic        EEPROM_DETECTED,
   input wire logic        SHARED_EEPROM,
   input wire logic        BOARD_INSERTED,
   input wire logic        CFG_REQ,
   input wire logic        CFG_WE,
   input wire logic [7:0]  CFG_ADDR,
   input wire logic [3:0]  CFG_BE,
   input wire logic [31:0] CFG_WDATA,
   input wire logic [31:0] CFG_RDATA,
   input wire logic        CFG_ACK,
   input wire logic        HOTSWAP_EVENT_N,
   input wire logic        STATUS_LED,
   input wire logic        EE_REQ,
   input wire logic        EE_WRITE,
   input wire logic [7:0]  EE_ADDR,
   input wire logic [7:0]  EE_WDATA,
   input wire logic        EE_DONE
);
   timeunit 1ns;
   timeprecision 1ps;

   logic pend;
   logic prim;
   logic rd_req;
   logic wr_hs;

   assign prim = !DUAL_PORT_CONFIG || PORT_PRIMARY_SELECT;
   assign rd_req = CFG_REQ && !CFG_WE && prim;
   assign wr_hs = CFG_REQ && CFG_WE && CFG_BE[2] && prim
                  && CFG_ADDR == OFS_HOTSWAP_CSR;

   default clocking @(posedge CLK); endclocking
   default disable iff (!RSTN || PRIMARY_PORT_RESET);

   ////////////////////////////////////////////////////////////////////////
   // byte request outstanding towards the EEPROM controller
   always_ff @(posedge CLK)
   begin
      if (!RSTN || PRIMARY_PORT_RESET)
         pend <= 1'b0;
      else if (EE_REQ)
         pend <= 1'b1;
      else if (EE_DONE)
         pend <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   hs_code_a: assert property (
      rd_req && CFG_ADDR == OFS_HOTSWAP_CSR |=> CFG_RDATA[21:20] ==
      PROG_IFACE_CODE && CFG_RDATA[15:0] == {($past(PRODUCT_INFO_ENABLE)
      && $past(EEPROM_DETECTED)) ? LINK_PRODINFO : LINK_END,
      CAP_CODE_HOTSWAP}) else $error("hot swap code or link wrong");
   sec_zero_a: assert property (
      CFG_REQ && !CFG_WE && !prim && CFG_ADDR >= OFS_HOTSWAP_CSR
      && CFG_ADDR <= OFS_PRODINFO_DATA |=> CFG_RDATA == 32'h0000_0000)
      else $error("secondary port read not zero");
   pd_cap_a: assert property (
      rd_req && CFG_ADDR == OFS_PRODINFO_CAP |=> CFG_RDATA[15:0] ==
      {LINK_END, CAP_CODE_PRODINFO}) else $error("product code wrong");
   data_off_a: assert property (
      rd_req && CFG_ADDR == OFS_PRODINFO_DATA && !(PRODUCT_INFO_ENABLE
      && EEPROM_DETECTED) |=> CFG_RDATA == 32'h0000_0000)
      else $error("disabled data read not zero");
   entry_a: assert property (
      BOARD_INSERTED ##1 !CFG_REQ ##1 rd_req && CFG_ADDR == OFS_HOTSWAP_CSR
      |=> CFG_RDATA[HS_ENTRY_BIT]) else $error("entry flag not set");
   led_a: assert property (
      wr_hs |=> ##1 STATUS_LED == $past(CFG_WDATA[HS_LED_BIT], 2))
      else $error("led does not follow write");
   mask_a: assert property (
      wr_hs && CFG_WDATA[HS_MASK_BIT] |=> ##1 HOTSWAP_EVENT_N)
      else $error("masked event still driven");
   ee_order_a: assert property (
      EE_REQ |-> !pend) else $error("byte request before done");
   ee_hold_a: assert property (
      pend |-> $stable(EE_ADDR) && $stable(EE_WRITE) && $stable(EE_WDATA))
      else $error("byte request changed while pending");
   ro_area_a: assert property (
      EE_REQ |-> EE_ADDR < 8'hc0 && !(EE_WRITE && SHARED_EEPROM
      && EE_ADDR < 8'h40)) else $error("byte outside allowed area");
   reset_a: assert property (disable iff (1'b0)
      !RSTN || PRIMARY_PORT_RESET |=> !CFG_ACK && !STATUS_LED && !EE_REQ
      && HOTSWAP_EVENT_N && CFG_RDATA == 32'h0000_0000)
      else $error("outputs not at reset values");
endmodule : phvc_capregs_checker

bind phvc_capregs phvc_capregs_checker u_phvc_capregs_checker (.*);

`default_nettype wire

/* File: sim/phvc_capregs_bench.sv */
/*
   Bench of the capability register block with an EEPROM byte model.
   Assumes the checker is bound from its own file.
*/
`default_nettype none

module phvc_capregs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import phvc_pkg::*;

   logic        clk, rst_n, port_rst, dual, psel, pd_en, ee_det, shared;
   logic        ent, rem, req, we, ack, ev_n, led, slow, e_req, e_wr;
   logic        e_done;
   logic [3:0]  be;
   logic [7:0]  addr, e_addr, e_wd, e_rd, a;
   logic [10:0] tbl [4] = '{11'h080, 11'h540, 11'h63e, 11'h3be};
   logic [31:0] wd, rdata, got, r, ex;
   logic [31:0] seed = 32'h7299_09e4;
   int          miscompares, total_checks;

   phvc_capregs u_phvc_capregs (.CLK(clk), .RSTN(rst_n),
      .PRIMARY_PORT_RESET(port_rst), .DUAL_PORT_CONFIG(dual),
      .PORT_PRIMARY_SELECT(psel), .PRODUCT_INFO_ENABLE(pd_en),
      .EEPROM_DETECTED(ee_det), .SHARED_EEPROM(shared),
      .BOARD_INSERTED(ent), .BOARD_REMOVED(rem), .CFG_REQ(req),
      .CFG_WE(we), .CFG_ADDR(addr), .CFG_BE(be), .CFG_WDATA(wd),
      .CFG_RDATA(rdata), .CFG_ACK(ack), .HOTSWAP_EVENT_N(ev_n),
      .STATUS_LED(led), .EE_REQ(e_req), .EE_WRITE(e_wr), .EE_ADDR(e_addr),
      .EE_WDATA(e_wd), .EE_RDATA(e_rd), .EE_DONE(e_done));
   phvc_ee_model u_phvc_ee_model (.clk(clk), .rst_n(rst_n & ~port_rst),
      .slow(slow), .ee_req(e_req), .ee_write(e_wr), .ee_addr(e_addr),
      .ee_wdata(e_wd), .ee_rdata(e_rd), .ee_done(e_done));

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic logic [31:0] hs_word(input logic [3:0] f,
                                           input logic lk);
      return {8'h00, f[3:2], PROG_IFACE_CODE, f[1], 1'b0, f[0], 1'b0,
              lk ? LINK_PRODINFO : LINK_END, CAP_CODE_HOTSWAP};
   endfunction : hs_word
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic cfg(input logic w, input logic [7:0] ad,
                      input logic [3:0] b, input logic [31:0] d);
      @(negedge clk);
      {req, we, addr, be, wd} = {1'b1, w, ad, b, d};
      @(negedge clk);
      req = 1'b0;
      got = rdata;
      chk("ack", 32'h1, {31'h0, ack});
   endtask : cfg
   task automatic xfer(input logic op, input logic [31:0] d);
      logic [7:0] old [4];
      int         n;
      for (int i = 0; i < 4; i++) old[i] = u_phvc_ee_model.mem[a + i];
      if (op)
         cfg(1, OFS_PRODINFO_DATA, 4'hf, d);
      cfg(1, OFS_PRODINFO_CAP, 4'hc, {op, 7'h0, a, 16'h0});
      n = 0;
      do
      begin
         cfg(0, OFS_PRODINFO_CAP, 4'h0, 0);
         n++;
      end
      while (got[31] === op && n < 300);
      chk("flag", {!op, 7'h0, a, LINK_END, CAP_CODE_PRODINFO}, got);
      cfg(0, OFS_PRODINFO_DATA, 4'h0, 0);
      for (int i = 0; i < 4; i++)
         if (op)
            chk("rom", (a + i < 192 && !(shared && a + i < 64)) ?
                d[8*i +: 8] : old[i], u_phvc_ee_model.mem[a + i]);
         else
            ex[8*i +: 8] = (a + i < 192) ? old[i] : 8'h00;
      if (!op)
         chk("data", ex, got);
   endtask : xfer
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_of_test

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      miscompares++;
      end_of_test();
   end
   initial
   begin
      {rst_n, port_rst, dual, psel, shared, ent, rem, req, we, slow} = 0;
      {pd_en, ee_det, be, addr, wd} = {2'b11, 44'h0};
      for (int i = 0; i < 256; i++) u_phvc_ee_model.mem[i] = 8'(rnd());
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      cfg(0, 8'h3c, 4'h0, 0);
      chk("line", 0, got);
      cfg(0, OFS_HOTSWAP_CSR, 4'h0, 0);
      chk("hs", hs_word(4'h0, 1), got);
      cfg(0, OFS_PRODINFO_CAP, 4'h0, 0);
      chk("cap", {16'h0, LINK_END, CAP_CODE_PRODINFO}, got);
      cfg(0, OFS_PRODINFO_DATA, 4'h0, 0);
      chk("data", 0, got);
      cfg(0, 8'h40, 4'h0, 0);
      chk("unmapped", 0, got);
      r = rnd();
      cfg(1, 8'h3c, 4'hf, r);
      cfg(0, 8'h3c, 4'h0, 0);
      chk("line", {24'h0, r[7:0]}, got);
      r = rnd() | 32'h0030_0000;
      cfg(1, OFS_HOTSWAP_CSR, 4'h4, r);
      cfg(0, OFS_HOTSWAP_CSR, 4'h0, 0);
      chk("hs", hs_word({2'b0, r[19], r[17]}, 1), got);
      chk("led", {31'h0, r[19]}, {31'h0, led});
      for (int k = 0; k < 2; k++)
      begin
         cfg(1, OFS_HOTSWAP_CSR, 4'h4, k << 17);
         @(negedge clk);
         {ent, rem} = {k == 0, k == 1};
         @(negedge clk);
         {ent, rem} = 2'b00;
         cfg(0, OFS_HOTSWAP_CSR, 4'h0, 0);
         chk("hs", hs_word({!k[0], k[0], 1'b0, k[0]}, 1), got);
         chk("event", k, {31'h0, ev_n});
         cfg(1, OFS_HOTSWAP_CSR, 4'h4, 32'h00c0_0000);
         cfg(0, OFS_HOTSWAP_CSR, 4'h0, 0);
         chk("hs", hs_word(4'h0, 1), got);
         chk("event", 1, {31'h0, ev_n});
      end
      for (int k = 0; k < 10; k++)
      begin
         r = (k < 4) ? {21'h0, tbl[k]} : rnd();
         {shared, slow} = r[9:8];
         a = (k < 4) ? r[7:0] : 8'(r[7:0] % 196);
         xfer(r[10], rnd());
      end
      ee_det = 1'b0;
      cfg(0, OFS_HOTSWAP_CSR, 4'h0, 0);
      chk("hs", hs_word(4'h0, 0), got);
      cfg(1, OFS_PRODINFO_DATA, 4'hf, rnd());
      cfg(0, OFS_PRODINFO_DATA, 4'h0, 0);
      chk("data", 0, got);
      {ee_det, dual} = 2'b11;
      cfg(1, OFS_HOTSWAP_CSR, 4'h4, 32'h0008_0000);
      for (int k = 0; k < 3; k++)
      begin
         cfg(0, OFS_HOTSWAP_CSR + 8'(4 * k), 4'h0, 0);
         chk("second", 0, got);
      end
      dual = 1'b0;
      cfg(0, OFS_HOTSWAP_CSR, 4'h0, 0);
      chk("hs", hs_word(4'h0, 1), got);
      {dual, psel} = 2'b11;
      cfg(1, OFS_HOTSWAP_CSR, 4'h4, 32'h0008_0000);
      @(negedge clk);
      port_rst = 1'b1;
      @(negedge clk);
      port_rst = 1'b0;
      cfg(0, OFS_HOTSWAP_CSR, 4'h0, 0);
      chk("hs", hs_word(4'h0, 1), got);
      chk("led", 0, {31'h0, led});
      end_of_test();
   end
endmodule : phvc_capregs_bench

`default_nettype wire
